// ---- maintenance_config_access_bench.sv ----
`timescale 1ns/1ps
module maintenance_config_access_bench;
   logic clk, nrst, ce, maint_awvalid, maint_awready, maint_wvalid;
   logic maint_wready, maint_bvalid, maint_bready, maint_arvalid, slv_done;
   logic maint_arready, maint_rvalid, maint_rready, rmt_req_valid, slv_write;
   logic rmt_req_ready, rmt_req_write, rmt_rsp_valid, rmt_rsp_write;
   logic rmt_rsp_err, in_valid, in_ready, in_maint, in_write, out_valid;
   logic out_ready, out_write, out_err, out_has_data;
   logic [1:0] maint_bresp, maint_rresp, in_xamsbs, slv_resp;
   logic [2:0] slv_sel;
   logic [3:0] dly;
   logic [7:0] rmt_req_hop, rmt_req_tag, rmt_rsp_tag, in_size, in_tag, out_tag;
   logic [9:0] local_window_base;
   logic [23:0] rmt_req_offs, slv_offs;
   logic [31:0] maint_awaddr, maint_wdata, maint_araddr, maint_rdata, in_data;
   logic [31:0] rmt_req_data, rmt_rsp_data, out_data, slv_wdata, slv_rdata;
   logic [33:0] in_addr;
   mca_pkg::mca_kind_t in_kind;
   int err_total, checked, cyc;
   mca_bridge dut (.*);
   mca_slave_model part (.*);
   always #5 clk = ~clk;
   // Hang guard
   always @(posedge clk) if (++cyc == 20000) begin
      err_total++;
      print_verdict;
   end
   task automatic cmp(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One maintenance access; address beat may trail data by lag cycles
   task automatic xfer(input bit w, input logic [31:0] a, d, input int lag,
                       output logic [31:0] rd, output logic [1:0] rs);
      bit at, wt, done;
      @(negedge clk);
      if (w) begin
         maint_awaddr = a;
         maint_wdata = d;
         maint_wvalid = 1;
         maint_bready = 1;
         maint_awvalid = (lag == 0);
      end else begin
         maint_araddr = a;
         maint_arvalid = 1;
         maint_rready = 1;
      end
      for (int n = 1; n < 300 && !done; n++) begin
         @(posedge clk);
         if (w && n <= lag) cmp(slv_sel, 3'h0, "write sent early");
         at = w ? maint_awvalid && maint_awready : maint_arvalid && maint_arready;
         wt = maint_wvalid && maint_wready;
         done = w ? maint_bvalid : maint_rvalid;
         rs = w ? maint_bresp : maint_rresp;
         rd = maint_rdata;
         @(negedge clk);
         if (w && at) maint_awvalid = 0;
         if (w && wt) maint_wvalid = 0;
         if (w && n == lag) maint_awvalid = 1;
         if (!w && at) maint_arvalid = 0;
      end
      if (w) maint_bready = 0;
      else maint_rready = 0;
      cmp(done, 1, "no response");
   endtask
   task automatic t_local;
      logic [31:0] a [3] = '{32'h103, 32'h404, 32'hFFFFF0};
      logic [31:0] d;
      logic [1:0] s;
      dly = 1;
      foreach (a[i]) begin
         xfer(1, a[i], {8'h5A, a[i][23:0]}, i, d, s);
         cmp(s, mca_pkg::RESP_OKAY, "write status");
         xfer(0, a[i] & 32'hFFFFFFFC, 0, 0, d, s);
         cmp(d, {8'h5A, a[i][23:0]}, "readback");
      end
      xfer(1, 32'h8, 32'hFFFFFFFF, 0, d, s);
      cmp(s, mca_pkg::RESP_OKAY, "read-only write status");
      xfer(0, 32'h8, 0, 0, d, s);
      cmp(d, 32'hC0000008, "read-only word");
      $display("local test done");
   endtask
   task automatic t_both;
      logic [31:0] d1, d2;
      logic [1:0] s1, s2;
      dly = 6;
      fork
         xfer(1, 32'h200, 32'h0BADF00D, 0, d1, s1);
         xfer(0, 32'h404, 0, 0, d2, s2);
      join
      cmp(d2, 32'h5A000404, "overlapped read");
      $display("overlap test done");
   endtask
   // Remote request must carry hop and tag; link answers after a while
   task automatic rmt(input logic [31:0] a, input bit w, input logic [7:0] tg);
      logic [31:0] d;
      logic [1:0] s;
      int n;
      fork
         xfer(w, a, 32'h11, 0, d, s);
         begin
            do @(posedge clk); while (!rmt_req_valid && ++n < 50);
            cmp(rmt_req_hop, a[31:24] - 8'h01, "hop");
            cmp(rmt_req_tag, tg, "tag");
            repeat (3) @(negedge clk);
            rmt_rsp_valid = 1;
            rmt_rsp_write = w;
            rmt_rsp_tag = tg;
            @(negedge clk);
            rmt_rsp_valid = 0;
         end
      join
      cmp(w ? s : d, w ? 0 : 32'hCAFE0001, "remote reply");
   endtask
   task automatic inp(input mca_pkg::mca_kind_t k, input logic [7:0] sz,
                      input bit w, e);
      int n;
      @(negedge clk);
      in_valid = 1;
      in_kind = k;
      in_size = sz;
      in_write = w;
      in_tag = in_tag + 8'h01;
      do @(posedge clk); while (!in_ready && ++n < 50);
      @(negedge clk);
      in_valid = 0;
      do @(posedge clk); while (!out_valid && ++n < 100);
      cmp(out_err, e, "in err");
      cmp({out_write, out_has_data}, {w, !w && !e}, "in flags");
      cmp(out_tag, in_tag, "in tag");
      @(posedge clk);
      cmp(out_valid, 0, "extra response");
   endtask
   initial begin
      {clk, nrst, maint_awvalid, maint_wvalid, maint_bready} = 0;
      {maint_arvalid, maint_rready, rmt_rsp_valid, rmt_rsp_err, in_valid} = 0;
      {in_maint, in_tag, cyc, err_total, checked} = 0;
      {ce, rmt_req_ready, out_ready} = 3'h7;
      rmt_rsp_data = 32'hCAFE0001;
      local_window_base = 10'h2A5;
      in_addr = {8'hA5, 26'h0000100};
      in_xamsbs = 2'h2;
      in_data = 32'hDEADBEEF;
      repeat (4) @(posedge clk);
      @(negedge clk);
      nrst = 1;
      t_local;
      t_both;
      rmt(32'h05000060, 0, 8'h00);
      rmt(32'h01000010, 1, 8'h01);
      $display("remote test done");
      inp(mca_pkg::MCA_KIND_OTHER, 8'h03, 1, 1);
      inp(mca_pkg::MCA_KIND_NREAD, 8'h07, 0, 1);
      inp(mca_pkg::MCA_KIND_NREAD, 8'h03, 0, 0);
      inp(mca_pkg::MCA_KIND_NWRITE, 8'h03, 1, 0);
      $display("incoming test done");
      print_verdict;
   end
endmodule

// ---- mca_bridge.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Only single 32-bit word accesses exist
// - Unassigned offsets complete normally, no error
// - Writes to read-only registers complete without error
// - Forward write once address and data taken
// - Write status returned on write-response channel
// - Block new write until response handed over
// - Forward read as soon as address taken
// - Block new read until response handed over
// - Read status and data on read-response channel
// - One read and one write outstanding together
// - Window-base match turns NREAD/NWRITE into maintenance
// - Remote write issued, then write response sent
// - Remote read gets exactly one read response
// - Fabric routes by offset to three slaves
// - Slave performs access and replies with status
// - Response built from request; data only good reads
// - Window hit of other types answered with error
// - Errored write leaves register unchanged
// - Size other than one word gives error
// - Nonzero top byte goes remote, hop minus one
// - Two lowest address bits ignored
// - Transaction tag starts at zero, increments
module mca_bridge (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        ce,
   // Maintenance port, write address and data
   input  wire logic                        maint_awvalid,
   output logic                             maint_awready,
   input  wire logic [mca_pkg::ADDR_W-1:0]  maint_awaddr,
   input  wire logic                        maint_wvalid,
   output logic                             maint_wready,
   input  wire logic [mca_pkg::DATA_W-1:0]  maint_wdata,
   // Maintenance port, write response
   output logic                             maint_bvalid,
   input  wire logic                        maint_bready,
   output logic [1:0]                       maint_bresp,
   // Maintenance port, read address
   input  wire logic                        maint_arvalid,
   output logic                             maint_arready,
   input  wire logic [mca_pkg::ADDR_W-1:0]  maint_araddr,
   // Maintenance port, read response
   output logic                             maint_rvalid,
   input  wire logic                        maint_rready,
   output logic [1:0]                       maint_rresp,
   output logic [mca_pkg::DATA_W-1:0]       maint_rdata,
   // Remote maintenance request out to the link
   output logic                             rmt_req_valid,
   input  wire logic                        rmt_req_ready,
   output logic                             rmt_req_write,
   output logic [7:0]                       rmt_req_hop,
   output logic [mca_pkg::TAG_W-1:0]        rmt_req_tag,
   output logic [mca_pkg::OFFS_W-1:0]       rmt_req_offs,
   output logic [mca_pkg::DATA_W-1:0]       rmt_req_data,
   // Remote maintenance response back from the link
   input  wire logic                        rmt_rsp_valid,
   input  wire logic                        rmt_rsp_write,
   input  wire logic [mca_pkg::TAG_W-1:0]   rmt_rsp_tag,
   input  wire logic                        rmt_rsp_err,
   input  wire logic [mca_pkg::DATA_W-1:0]  rmt_rsp_data,
   // Incoming request from the link partner
   input  wire logic                        in_valid,
   output logic                             in_ready,
   input  wire logic                        in_maint,
   input  wire logic                        in_write,
   input  wire mca_pkg::mca_kind_t          in_kind,
   input  wire logic [mca_pkg::SIZE_W-1:0]  in_size,
   input  wire logic [mca_pkg::RADDR_W-1:0] in_addr,
   input  wire logic [1:0]                  in_xamsbs,
   input  wire logic [mca_pkg::TAG_W-1:0]   in_tag,
   input  wire logic [mca_pkg::DATA_W-1:0]  in_data,
   input  wire logic [mca_pkg::WIN_W-1:0]   local_window_base,
   // Maintenance response to the link partner
   output logic                             out_valid,
   input  wire logic                        out_ready,
   output logic                             out_write,
   output logic [mca_pkg::TAG_W-1:0]        out_tag,
   output logic                             out_err,
   output logic                             out_has_data,
   output logic [mca_pkg::DATA_W-1:0]       out_data,
   // Register slave side, shared reply bus
   output logic [2:0]                       slv_sel,
   output logic                             slv_write,
   output logic [mca_pkg::OFFS_W-1:0]       slv_offs,
   output logic [mca_pkg::DATA_W-1:0]       slv_wdata,
   input  wire logic                        slv_done,
   input  wire logic [1:0]                  slv_resp,
   input  wire logic [mca_pkg::DATA_W-1:0]  slv_rdata
);
   // Who owns the configuration master right now
   typedef enum logic [1:0] {MCA_O_NONE, MCA_O_WR, MCA_O_RD, MCA_O_IN}
      mca_own_t;

   // Write path state
   logic                         aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic                         wbusy_q, wbusy_d, wrmt_q, wrmt_d;
   logic [mca_pkg::ADDR_W-1:0]   awaddr_q, awaddr_d;
   logic [mca_pkg::DATA_W-1:0]   wdata_q, wdata_d;
   logic [1:0]                   bresp_q, bresp_d;
   logic                         bvalid_q, bvalid_d, wsent_q, wsent_d;
   // Read path state
   logic                         rbusy_q, rbusy_d, rrmt_q, rrmt_d;
   logic                         rsent_q, rsent_d;
   logic [mca_pkg::ADDR_W-1:0]   araddr_q, araddr_d;
   logic [1:0]                   rresp_q, rresp_d;
   logic [mca_pkg::DATA_W-1:0]   rdata_q, rdata_d;
   logic                         rvalid_q, rvalid_d;
   logic [mca_pkg::TAG_W-1:0]    wtag_q, wtag_d, rtag_q, rtag_d;
   logic [mca_pkg::TAG_W-1:0]    tag_q, tag_d;
   // Incoming request state
   logic                         ibusy_q, ibusy_d, iwr_q, iwr_d;
   logic                         ierr_q, ierr_d, ivalid_q, ivalid_d;
   logic [mca_pkg::TAG_W-1:0]    itag_q, itag_d;
   logic [mca_pkg::OFFS_W-1:0]   ioffs_q, ioffs_d;
   logic [mca_pkg::DATA_W-1:0]   idata_q, idata_d, odata_q, odata_d;
   logic                         ohas_q, ohas_d;
   mca_own_t                     own_q, own_d;
   // Fabric handshake and request decode
   logic                         f_valid, f_ready, f_rsp_valid, f_write;
   logic [mca_pkg::OFFS_W-1:0]   f_offs;
   logic                         win_hit, in_take, in_bad, wr_go, rd_go;
   logic                         aw_take, w_take, ar_take, slv_err;

   // Handshakes: each channel refuses while its access is pending
   assign maint_awready = !aw_have_q && !wbusy_q;
   assign maint_wready  = !w_have_q && !wbusy_q;
   assign maint_arready = !rbusy_q;
   assign aw_take = maint_awvalid && maint_awready;
   assign w_take  = maint_wvalid && maint_wready;
   assign ar_take = maint_arvalid && maint_arready;
   assign in_ready = !ibusy_q;
   assign in_take  = in_valid && in_ready;
   assign maint_bvalid = bvalid_q;
   assign maint_bresp  = bresp_q;
   assign maint_rvalid = rvalid_q;
   assign maint_rresp  = rresp_q;
   assign maint_rdata  = rdata_q;
   assign out_valid    = ivalid_q;
   assign out_write    = iwr_q;
   assign out_tag      = itag_q;
   assign out_err      = ierr_q;
   assign out_has_data = ohas_q;
   assign out_data     = odata_q;
   assign slv_err = (slv_resp != mca_pkg::RESP_OKAY);

   // Window match on the two extended bits and the top eight address bits
   assign win_hit = ({in_xamsbs, in_addr[mca_pkg::RADDR_W-1 -: 8]}
                     == local_window_base);
   // Non-maintenance requests of other kinds and any size but one word give an error
   assign in_bad = (!in_maint && in_kind == mca_pkg::MCA_KIND_OTHER)
                   || (in_size != mca_pkg::SIZE_WORD);

   // Write ready once both beats are held; reads go as soon as address held
   assign wr_go = wbusy_q && !wsent_q;
   assign rd_go = rbusy_q && !rsent_q;

   // Remote request carries the decremented hop and the running tag
   assign rmt_req_valid = rmt_req_write || (rd_go && rrmt_q);
   assign rmt_req_write = wr_go && wrmt_q;
   assign rmt_req_hop   = rmt_req_write ? awaddr_q[31:24] - 8'h01
                                        : araddr_q[31:24] - 8'h01;
   assign rmt_req_tag   = tag_q;
   assign rmt_req_offs  = rmt_req_write ? {awaddr_q[23:2], 2'h0}
                                        : {araddr_q[23:2], 2'h0};
   assign rmt_req_data  = wdata_q;

   // Master request to the fabric, owner held until its reply is taken
   always_comb begin
      f_valid = 1'b0;
      f_write = 1'b0;
      f_offs  = '0;
      unique case (own_q)
         MCA_O_WR: begin
            f_valid = 1'b1;
            f_write = 1'b1;
            f_offs  = {awaddr_q[23:2], 2'h0};
         end
         MCA_O_RD: begin
            f_valid = 1'b1;
            f_offs  = {araddr_q[23:2], 2'h0};
         end
         MCA_O_IN: begin
            f_valid = 1'b1;
            f_write = iwr_q;
            f_offs  = {ioffs_q[23:2], 2'h0};
         end
         MCA_O_NONE: begin
            f_valid = 1'b0;
         end
      endcase
   end
   assign slv_wdata = (own_q == MCA_O_IN) ? idata_q : wdata_q;

   mca_fabric u_fabric (
      .clk       (clk),
      .nrst      (nrst),
      .ce        (ce),
      .req_valid (f_valid && f_ready),
      .req_ready (f_ready),
      .req_write (f_write),
      .req_offs  (f_offs),
      .rsp_valid (f_rsp_valid),
      .rsp_ready (1'b1),
      .slv_sel   (slv_sel),
      .slv_write (slv_write),
      .slv_offs  (slv_offs),
      .slv_done  (slv_done)
   );

   // Next state of both user paths, the incoming path and the master owner
   always_comb begin
      aw_have_d = aw_have_q; w_have_d = w_have_q; wbusy_d = wbusy_q;
      wrmt_d = wrmt_q; awaddr_d = awaddr_q; wdata_d = wdata_q;
      bresp_d = bresp_q; bvalid_d = bvalid_q; wsent_d = wsent_q;
      rbusy_d = rbusy_q; rrmt_d = rrmt_q; rsent_d = rsent_q;
      araddr_d = araddr_q; rresp_d = rresp_q; rdata_d = rdata_q;
      rvalid_d = rvalid_q; wtag_d = wtag_q; rtag_d = rtag_q; tag_d = tag_q;
      ibusy_d = ibusy_q; iwr_d = iwr_q; ierr_d = ierr_q; ivalid_d = ivalid_q;
      itag_d = itag_q; ioffs_d = ioffs_q; idata_d = idata_q;
      odata_d = odata_q; ohas_d = ohas_q; own_d = own_q;
      // Capture the beats; the two may come in either order
      if (aw_take) begin
         aw_have_d = 1'b1;
         awaddr_d  = maint_awaddr;
      end
      if (w_take) begin
         w_have_d = 1'b1;
         wdata_d  = maint_wdata;
      end
      if ((aw_have_q || aw_take) && (w_have_q || w_take) && !wbusy_q) begin
         wbusy_d = 1'b1;
         wsent_d = 1'b0;
         wrmt_d  = aw_take ? (maint_awaddr[31:24] != 8'h00)
                           : (awaddr_q[31:24] != 8'h00);
      end
      if (ar_take) begin
         rbusy_d  = 1'b1;
         rsent_d  = 1'b0;
         araddr_d = maint_araddr;
         rrmt_d   = (maint_araddr[31:24] != 8'h00);
      end
      // Remote requests: tag advances once per request sent
      if (rmt_req_valid && rmt_req_ready) begin
         tag_d = tag_q + 8'h01;
         if (rmt_req_write) begin
            wsent_d = 1'b1;
            wtag_d  = tag_q;
         end else begin
            rsent_d = 1'b1;
            rtag_d  = tag_q;
         end
      end
      // Remote responses matched by tag
      if (rmt_rsp_valid && rmt_rsp_write && wbusy_q && wrmt_q && wsent_q
          && rmt_rsp_tag == wtag_q && !bvalid_q) begin
         bvalid_d = 1'b1;
         bresp_d  = rmt_rsp_err ? mca_pkg::RESP_SLVERR : mca_pkg::RESP_OKAY;
      end
      if (rmt_rsp_valid && !rmt_rsp_write && rbusy_q && rrmt_q && rsent_q
          && rmt_rsp_tag == rtag_q && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d  = rmt_rsp_err ? mca_pkg::RESP_SLVERR : mca_pkg::RESP_OKAY;
         rdata_d  = rmt_rsp_data;
      end
      // Accept an incoming request; errored ones skip the fabric
      if (in_take && (in_maint || win_hit)) begin
         ibusy_d = 1'b1;
         iwr_d   = in_maint ? in_write : (in_kind != mca_pkg::MCA_KIND_NREAD);
         itag_d  = in_tag;
         ioffs_d = in_addr[mca_pkg::OFFS_W-1:0];
         idata_d = in_data;
         ierr_d  = in_bad;
         if (in_bad) begin
            ivalid_d = 1'b1;
            ohas_d   = 1'b0;
         end
      end
      // Grant the configuration master; user write first, then read, then link
      if (own_q == MCA_O_NONE && f_ready) begin
         if (wr_go && !wrmt_q)
            own_d = MCA_O_WR;
         else if (rd_go && !rrmt_q)
            own_d = MCA_O_RD;
         else if (ibusy_q && !ivalid_q)
            own_d = MCA_O_IN;
      end else if (own_q != MCA_O_NONE && f_rsp_valid) begin
         own_d = MCA_O_NONE;
         unique case (own_q)
            MCA_O_WR: begin
               wsent_d  = 1'b1;
               bvalid_d = 1'b1;
               bresp_d  = slv_err ? mca_pkg::RESP_SLVERR
                                  : mca_pkg::RESP_OKAY;
            end
            MCA_O_RD: begin
               rsent_d  = 1'b1;
               rvalid_d = 1'b1;
               rresp_d  = slv_err ? mca_pkg::RESP_SLVERR : mca_pkg::RESP_OKAY;
               rdata_d  = slv_rdata;
            end
            MCA_O_IN: begin
               ivalid_d = 1'b1;
               ierr_d   = slv_err;
               ohas_d   = !iwr_q && !slv_err;
               odata_d  = slv_rdata;
            end
            MCA_O_NONE: begin
               own_d = MCA_O_NONE;
            end
         endcase
      end
      // Hand-over frees each path independently
      if (bvalid_q && maint_bready) begin
         bvalid_d = 1'b0; aw_have_d = 1'b0; w_have_d = 1'b0; wbusy_d = 1'b0;
      end
      if (rvalid_q && maint_rready) begin
         rvalid_d = 1'b0; rbusy_d = 1'b0;
      end
      if (ivalid_q && out_ready) begin
         ivalid_d = 1'b0; ibusy_d = 1'b0;
      end
   end

   // Registers of all paths
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_q <= 1'b0; w_have_q <= 1'b0; wbusy_q <= 1'b0;
         wrmt_q <= 1'b0; awaddr_q <= '0; wdata_q <= '0;
         bresp_q <= mca_pkg::RESP_OKAY; bvalid_q <= 1'b0; wsent_q <= 1'b0;
         rbusy_q <= 1'b0; rrmt_q <= 1'b0; rsent_q <= 1'b0; araddr_q <= '0;
         rresp_q <= mca_pkg::RESP_OKAY; rdata_q <= '0; rvalid_q <= 1'b0;
         wtag_q <= '0; rtag_q <= '0; tag_q <= mca_pkg::TAG_RESET;
         ibusy_q <= 1'b0; iwr_q <= 1'b0; ierr_q <= 1'b0; ivalid_q <= 1'b0;
         itag_q <= '0; ioffs_q <= '0; idata_q <= '0; odata_q <= '0;
         ohas_q <= 1'b0; own_q <= MCA_O_NONE;
      end else if (ce) begin
         aw_have_q <= aw_have_d; w_have_q <= w_have_d; wbusy_q <= wbusy_d;
         wrmt_q <= wrmt_d; awaddr_q <= awaddr_d; wdata_q <= wdata_d;
         bresp_q <= bresp_d; bvalid_q <= bvalid_d; wsent_q <= wsent_d;
         rbusy_q <= rbusy_d; rrmt_q <= rrmt_d; rsent_q <= rsent_d;
         araddr_q <= araddr_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
         rvalid_q <= rvalid_d; wtag_q <= wtag_d; rtag_q <= rtag_d;
         tag_q <= tag_d; ibusy_q <= ibusy_d; iwr_q <= iwr_d;
         ierr_q <= ierr_d; ivalid_q <= ivalid_d; itag_q <= itag_d;
         ioffs_q <= ioffs_d; idata_q <= idata_d; odata_q <= odata_d;
         ohas_q <= ohas_d; own_q <= own_d;
      end
   end
endmodule

// ---- mca_checker.sv ----
`timescale 1ns/1ps
module mca_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Watched handshakes and flags
   input wire logic        maint_awready, maint_wready, maint_bvalid,
   input wire logic        maint_bready, maint_arvalid, maint_arready,
   input wire logic        maint_rvalid, maint_rready, rmt_req_valid,
   input wire logic        out_valid, out_err, out_has_data,
   // Watched data
   input wire logic [1:0]  maint_bresp,
   input wire logic [2:0]  slv_sel,
   input wire logic [23:0] slv_offs,
   input wire logic [31:0] maint_araddr, maint_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Pending responses block the matching request channels
   chk_wr_block: assert property (maint_bvalid |-> !maint_awready &&
      !maint_wready) else $error("write beat taken while response pending");
   chk_rd_block: assert property (maint_rvalid |-> !maint_arready)
      else $error("read address taken while response pending");
   // Responses stand until taken
   chk_b_stand: assert property (maint_bvalid && !maint_bready |=>
      maint_bvalid && $stable(maint_bresp)) else $error("write reply dropped");
   chk_r_stand: assert property (maint_rvalid && !maint_rready |=>
      maint_rvalid && $stable(maint_rdata)) else $error("read reply dropped");
   // Fabric selects one slave, chosen by offset
   chk_one_slave: assert property ($onehot0(slv_sel))
      else $error("more than one slave selected");
   chk_route_ends: assert property (slv_sel[0] && slv_offs < 24'h000400 ||
      slv_sel[2] && slv_offs >= 24'h000800 || !slv_sel[0] && !slv_sel[2])
      else $error("slave chosen against offset");
   // A taken read goes out promptly, locally or to the link
   chk_rd_fwd: assert property (maint_arvalid && maint_arready |->
      ##[1:40] (slv_sel != 3'h0 || rmt_req_valid))
      else $error("read not forwarded");
   chk_data_good: assert property (out_valid && out_has_data |-> !out_err)
      else $error("data sent with an error response");
endmodule
bind mca_bridge mca_checker chk (.*);

// ---- mca_fabric.sv ----
`timescale 1ns/1ps
// Routes one 32-bit access at a time to one of three register slaves
module mca_fabric (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        ce,
   // Request from the configuration master
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire logic                        req_write,
   input  wire logic [mca_pkg::OFFS_W-1:0]  req_offs,
   // Reply to the configuration master
   output logic                             rsp_valid,
   input  wire logic                        rsp_ready,
   // Slave request strobes, one per slave
   output logic [2:0]                       slv_sel,
   output logic                             slv_write,
   output logic [mca_pkg::OFFS_W-1:0]       slv_offs,
   // Slave reply (the three slaves share one reply bus)
   input  wire logic                        slv_done
);
   typedef enum logic [1:0] {MCA_F_IDLE, MCA_F_WAIT, MCA_F_RESP} mca_fst_t;
   mca_fst_t                       st_q, st_d;
   logic [2:0]                     sel_q, sel_d;
   logic                           wr_q, wr_d;
   logic [mca_pkg::OFFS_W-1:0]     offs_q, offs_d;

   assign req_ready = (st_q == MCA_F_IDLE);
   assign rsp_valid = (st_q == MCA_F_RESP);
   assign slv_sel   = (st_q == MCA_F_WAIT) ? sel_q : 3'h0;
   assign slv_write = wr_q;
   assign slv_offs  = offs_q;

   // Decode the offset into one slave; unassigned offsets go to the link slave
   always_comb begin
      st_d   = st_q;
      sel_d  = sel_q;
      wr_d   = wr_q;
      offs_d = offs_q;
      unique case (st_q)
         MCA_F_IDLE: begin
            if (req_valid) begin
               wr_d   = req_write;
               offs_d = req_offs;
               st_d   = MCA_F_WAIT;
               if (req_offs < mca_pkg::QUEUE_BASE)
                  sel_d = 3'h1;
               else if (req_offs < mca_pkg::LINK_BASE)
                  sel_d = 3'h2;
               else
                  sel_d = 3'h4;
            end
         end
         MCA_F_WAIT: begin
            if (slv_done) begin
               st_d = MCA_F_RESP;
            end
         end
         MCA_F_RESP: begin
            if (rsp_ready) begin
               st_d = MCA_F_IDLE;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q   <= MCA_F_IDLE;
         sel_q  <= 3'h0;
         wr_q   <= 1'b0;
         offs_q <= '0;
      end else if (ce) begin
         st_q   <= st_d;
         sel_q  <= sel_d;
         wr_q   <= wr_d;
         offs_q <= offs_d;
      end
   end
endmodule

// ---- mca_pkg.sv ----
package mca_pkg;
   // Data and address widths of the configuration path
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int OFFS_W = 24;
   localparam int TAG_W  = 8;
   localparam int HOP_MSB = 31;
   localparam int HOP_LSB = 24;
   localparam int WIN_W  = 10;
   localparam int RADDR_W = 34;
   localparam int SIZE_W = 8;

   // Response codes as carried on the lightweight memory-mapped port
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Size field holding bytes minus one; a single word is four bytes
   localparam logic [SIZE_W-1:0] SIZE_WORD = 8'h03;

   // Reset value of the transaction tag
   localparam logic [TAG_W-1:0] TAG_RESET = 8'h00;

   // Offset split between the three register slaves
   localparam logic [OFFS_W-1:0] QUEUE_BASE = 24'h000400;
   localparam logic [OFFS_W-1:0] LINK_BASE  = 24'h000800;
   localparam logic [OFFS_W-1:0] LINK_END   = 24'h000C00;

   // Remote request kinds
   typedef enum logic [1:0] {
      MCA_KIND_NREAD,
      MCA_KIND_NWRITE,
      MCA_KIND_NWRITE_R,
      MCA_KIND_OTHER
   } mca_kind_t;

   // Slave selection of the fabric
   typedef enum logic [1:0] {
      MCA_SEL_TRANS,
      MCA_SEL_QUEUE,
      MCA_SEL_LINK
   } mca_sel_t;
endpackage

// ---- mca_slave_model.sv ----
`timescale 1ns/1ps
module mca_slave_model (
   // Clock, reset and reply delay
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [3:0]  dly,
   // Register slave side of the block
   input wire logic [2:0]  slv_sel,
   input wire logic        slv_write,
   input wire logic [23:0] slv_offs,
   input wire logic [31:0] slv_wdata,
   output logic            slv_done,
   output logic [1:0]      slv_resp,
   output logic [31:0]     slv_rdata
);
   logic [31:0] mem [int];
   int          cnt;
   // Offsets below 0x10 are read-only capability words; rest is plain RAM
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt = 0;
         slv_done <= 1'b0;
         slv_resp <= 2'h0;
         slv_rdata <= 32'h0;
      end else if (slv_sel != 3'h0 && !slv_done && cnt < dly) begin
         cnt = cnt + 1;
      end else if (slv_sel != 3'h0 && !slv_done) begin
         cnt = 0;
         slv_done <= 1'b1;
         slv_resp <= mca_pkg::RESP_OKAY;
         slv_rdata <= slv_offs < 24'h10 ? {8'hC0, slv_offs} :
            mem.exists(slv_offs) ? mem[slv_offs] : 32'h0;
         if (slv_write && slv_offs >= 24'h10) mem[slv_offs] = slv_wdata;
      end else begin
         slv_done <= 1'b0;
         if (!slv_done) slv_rdata <= ~slv_rdata; // Held two cycles, then spoiled
      end
   end
endmodule
